// File: include/pic_params.svh
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// register byte addresses
`define PIC_ADDR_MODE_LO 32'hfffec000
`define PIC_ADDR_MODE_HI 32'hfffec004
`define PIC_ADDR_ENABLE 32'hfffec008
`define PIC_ADDR_LEVEL0 32'hfffec010
`define PIC_ADDR_LEVEL7 32'hfffec02c
`define PIC_ADDR_MASK 32'hfffec040
`define PIC_ADDR_CLEAR 32'hfffec060
`define PIC_ADDR_PENDING 32'hfffec080
`define PIC_ADDR_CURRENT 32'hfffec0a0

// field positions
`define PIC_ENABLE_BIT 0
`define PIC_CLR_EN_BIT 8
`define PIC_LVL_HI_LSB 8
`define PIC_CUR_IF_BIT 16
`define PIC_CUR_LVL_LSB 8

// reset values and fixed codes
`define PIC_VEC_IDLE 5'h1f
`define PIC_LVL_OFF 3'h0
`define PIC_CODE_TOP 1'b1
`define PIC_RSVD_SRC 16'h1800
`define PIC_NUM_SRC 16

`endif

// File: include/pic_pkg.sv
package pic_pkg;
    // per-source detection mode, two bits each in the mode registers
    typedef enum logic [1:0] {
        PIC_DET_LOW = 2'b00,
        PIC_DET_HIGH = 2'b01,
        PIC_DET_RISE = 2'b10,
        PIC_DET_FALL = 2'b11
    } pic_detect_e;

    typedef logic [2:0] pic_level_t;

    // state of the source detector
    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] prev;
        logic [15:0] edgeHit;
        logic [15:0] pending;
    } pic_det_s;

    // state of the controller
    typedef struct packed {
        logic [31:0] modeWord;
        logic enable;
        logic [15:0][2:0] levels;
        pic_level_t mask;
        logic [3:0] clrSel;
        pic_level_t curLevel;
        logic [4:0] curVector;
        logic active;
        logic [31:0] rdData;
    } pic_ctrl_s;
endpackage

// File: src/pic_source_detect.sv
`timescale 1ns/1ps
`include "pic_params.svh"

module pic_source_detect #(
    parameter int NUM_SRC = 16
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [NUM_SRC-1:0] srcLine, // raw request lines
    input wire logic [2*NUM_SRC-1:0] modeWord, // two mode bits per source
    input wire logic clrStrobe, // one-cycle edge clear
    input wire logic [3:0] clrSel, // source to clear
    output logic [NUM_SRC-1:0] pending // registered pending set
);
    import pic_pkg::*;

    pic_det_s st;
    pic_det_s next_st;

    // detection per source; lines come from pins so pass two flops first
    always_comb begin
        pic_detect_e mode;
        logic rise;
        logic fall;
        logic clr;
        mode = PIC_DET_LOW;
        rise = 1'b0;
        fall = 1'b0;
        clr = 1'b0;
        next_st = st;
        next_st.sync1 = 16'(srcLine);
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        for (int i = 0; i < NUM_SRC; i++) begin
            mode = pic_detect_e'(modeWord[2*i +: 2]);
            rise = st.sync2[i] & ~st.prev[i];
            fall = ~st.sync2[i] & st.prev[i];
            clr = clrStrobe && (clrSel == 4'(i));
            unique case (mode)
                PIC_DET_LOW: begin
                    // no latch held for level sources, line alone decides
                    next_st.edgeHit[i] = 1'b0;
                    next_st.pending[i] = ~st.sync2[i];
                end
                PIC_DET_HIGH: begin
                    next_st.edgeHit[i] = 1'b0;
                    next_st.pending[i] = st.sync2[i];
                end
                PIC_DET_RISE: begin
                    // a new edge in the clear cycle survives
                    next_st.edgeHit[i] = (st.edgeHit[i] & ~clr) | rise;
                    next_st.pending[i] = next_st.edgeHit[i];
                end
                PIC_DET_FALL: begin
                    next_st.edgeHit[i] = (st.edgeHit[i] & ~clr) | fall;
                    next_st.pending[i] = next_st.edgeHit[i];
                end
            endcase
        end
    end

    // state register; low-level default means an idle high line is quiet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // sync chain starts at the idle-high line level so that no false
            // edge or low-level request shows in the first cycles after reset
            st <= '0;
            st.sync1 <= '1;
            st.sync2 <= '1;
            st.prev <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign pending = st.pending[NUM_SRC-1:0];
endmodule

// File: src/pic_controller.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "pic_params.svh"

// Contract
// - pending status shows every request, ignoring levels
// - flag bit 16 low when request, reset 1
// - current status bits 10:8 give delivered level
// - current status bits 4:0 give vector, reset 1f
// - eight on-chip plus six external sources
// - core code is one then source number
// - equal levels resolved by lowest vector
// - detect high, low, rising, falling; low default
// - clear write with enable drops edge latch
// - three-bit level, seven highest, zero disabled
// - below mask ignored, equal accepted, zero blocks
// - only strictly higher level preempts current one
// - current level set zero keeps vector
// - raised mask hides all lower requests
// - clear enable self clears, reads zero

module pic_controller #(
    parameter int NUM_SRC = `PIC_NUM_SRC
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [31:0] regAddr, // register byte address
    input wire logic [31:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdData, // read data, cycle after strobe
    input wire logic [NUM_SRC-1:0] srcLine, // request lines, pins and on-chip
    output logic coreReq, // interrupt request to core
    output pic_pkg::pic_level_t coreLevel, // delivered level
    output logic [5:0] coreCode // delivered cause code
);
    import pic_pkg::*;

    pic_ctrl_s st;
    pic_ctrl_s next_st;
    logic [NUM_SRC-1:0] rawPending;
    logic [NUM_SRC-1:0] pending;
    logic clrStrobe;
    logic [3:0] clrSelNow;

    // a level may be delivered only when enabled, nonzero and not masked
    function automatic logic eligible(input pic_level_t lvl, input pic_level_t msk,
                                      input logic en);
        eligible = en && (lvl != `PIC_LVL_OFF)
            && (msk != `PIC_LVL_OFF) && (lvl >= msk);
    endfunction

    // address hits a given register
    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        hit = (a == b);
    endfunction

    // edge clear fires only when the same write carries the enable bit
    assign clrStrobe = regWr && hit(regAddr, `PIC_ADDR_CLEAR)
        && regWrData[`PIC_CLR_EN_BIT];
    assign clrSelNow = regWrData[3:0];

    pic_source_detect #(
        .NUM_SRC(NUM_SRC)
    ) u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .srcLine(srcLine),
        .modeWord(st.modeWord[2*NUM_SRC-1:0]),
        .clrStrobe(clrStrobe),
        .clrSel(clrSelNow),
        .pending(rawPending)
    );

    // vectors 11 and 12 have no source behind them
    assign pending = rawPending & ~NUM_SRC'(`PIC_RSVD_SRC);

    // register writes, arbitration and read mux
    always_comb begin
        pic_level_t candLevel;
        logic [4:0] candVector;
        logic candValid;
        logic keep;
        logic [2:0] lvlIdx;
        candLevel = `PIC_LVL_OFF;
        candVector = `PIC_VEC_IDLE;
        candValid = 1'b0;
        keep = 1'b0;
        lvlIdx = 3'h0;
        next_st = st;

        // register writes
        if (regWr) begin
            if (hit(regAddr, `PIC_ADDR_MODE_LO)) begin
                next_st.modeWord[15:0] = regWrData[15:0];
            end
            if (hit(regAddr, `PIC_ADDR_MODE_HI)) begin
                next_st.modeWord[31:16] = regWrData[15:0];
            end
            if (hit(regAddr, `PIC_ADDR_ENABLE)) begin
                next_st.enable = regWrData[`PIC_ENABLE_BIT];
            end
            if (regAddr >= `PIC_ADDR_LEVEL0 && regAddr <= `PIC_ADDR_LEVEL7
                && regAddr[1:0] == 2'h0) begin
                // each level register holds an even and an odd source
                lvlIdx = 3'(regAddr[4:2] - 3'h4);
                next_st.levels[{lvlIdx, 1'b0}] = regWrData[2:0];
                next_st.levels[{lvlIdx, 1'b1}] =
                    regWrData[`PIC_LVL_HI_LSB +: 3];
            end
            if (hit(regAddr, `PIC_ADDR_MASK)) begin
                next_st.mask = regWrData[2:0];
            end
            if (hit(regAddr, `PIC_ADDR_CLEAR)) begin
                // only the source field is kept; enable bit is never stored
                next_st.clrSel = regWrData[3:0];
            end
        end

        // best candidate: strict compare keeps the lowest vector on ties
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pending[i] && eligible(st.levels[i], st.mask, st.enable)
                && (!candValid || st.levels[i] > candLevel)) begin
                candValid = 1'b1;
                candLevel = st.levels[i];
                candVector = 5'(i);
            end
        end

        // current holds while enabled, its pending bit is set and its latched level passes
        // the mask; its programmed level is not looked at again
        keep = st.active && pending[st.curVector[3:0]]
            && eligible(st.curLevel, st.mask, st.enable);

        if (keep) begin
            if (candValid && candLevel > st.curLevel) begin
                next_st.curLevel = candLevel;
                next_st.curVector = candVector;
            end
        end else if (candValid) begin
            next_st.active = 1'b1;
            next_st.curLevel = candLevel;
            next_st.curVector = candVector;
        end else begin
            next_st.active = 1'b0;
            next_st.curLevel = `PIC_LVL_OFF;
            next_st.curVector = `PIC_VEC_IDLE;
        end

        // read data valid only in the cycle after the strobe
        next_st.rdData = 32'h0;
        if (regRd) begin
            if (hit(regAddr, `PIC_ADDR_PENDING)) begin
                next_st.rdData = {16'h0, 16'(pending)};
            end
            if (hit(regAddr, `PIC_ADDR_CURRENT)) begin
                next_st.rdData[`PIC_CUR_IF_BIT] = ~st.active;
                next_st.rdData[`PIC_CUR_LVL_LSB +: 3] = st.curLevel;
                next_st.rdData[4:0] = st.curVector;
            end
            if (hit(regAddr, `PIC_ADDR_MODE_LO)) begin
                next_st.rdData[15:0] = st.modeWord[15:0];
            end
            if (hit(regAddr, `PIC_ADDR_MODE_HI)) begin
                next_st.rdData[15:0] = st.modeWord[31:16];
            end
            if (hit(regAddr, `PIC_ADDR_ENABLE)) begin
                next_st.rdData[`PIC_ENABLE_BIT] = st.enable;
            end
            if (regAddr >= `PIC_ADDR_LEVEL0 && regAddr <= `PIC_ADDR_LEVEL7
                && regAddr[1:0] == 2'h0) begin
                lvlIdx = 3'(regAddr[4:2] - 3'h4);
                next_st.rdData[2:0] = st.levels[{lvlIdx, 1'b0}];
                next_st.rdData[`PIC_LVL_HI_LSB +: 3] = st.levels[{lvlIdx, 1'b1}];
            end
            if (hit(regAddr, `PIC_ADDR_MASK)) begin
                next_st.rdData[2:0] = st.mask;
            end
            if (hit(regAddr, `PIC_ADDR_CLEAR)) begin
                // enable bit position always reads zero
                next_st.rdData[3:0] = st.clrSel;
            end
        end
    end

    // one register for the whole state; idle vector 1f out of reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.curVector <= `PIC_VEC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // all core-facing outputs straight from flops
    assign regRdData = st.rdData;
    assign coreReq = st.active;
    assign coreLevel = st.curLevel;
    assign coreCode = {`PIC_CODE_TOP, st.curVector};
endmodule

// File: verification/pic_core_model.sv
`timescale 1ns/1ps
module pic_core_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic coreReq, // request from controller
    input wire logic [5:0] coreCode, // delivered cause code
    output logic [5:0] causeIp // cause bits seen by the core
);
    // cause bits follow the code while requested, hold it once dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            causeIp <= 6'h00;
        end else if (coreReq) begin
            causeIp <= coreCode;
        end
    end
endmodule

// File: verification/pic_controller_sva.sv
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_controller_sva (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [31:0] regAddr, // register address
    input wire logic [31:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [31:0] regRdData, // read data
    input wire logic [15:0] srcLine, // request lines
    input wire logic coreReq, // request to core
    input wire pic_pkg::pic_level_t coreLevel, // delivered level
    input wire logic [5:0] coreCode // delivered code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // single-cycle bus events
    sequence s_mask_off;
        regWr && regAddr == `PIC_ADDR_MASK && regWrData[2:0] == 3'h0;
    endsequence
    sequence s_read_cur;
        regRd && regAddr == `PIC_ADDR_CURRENT;
    endsequence
    chk_code_top: assert property (coreReq |-> coreCode[5])
        else $error("code top bit low");
    chk_idle_code: assert property (!coreReq |-> coreCode == 6'h3f)
        else $error("idle code wrong");
    chk_level_live: assert property (coreReq |-> coreLevel != 3'h0)
        else $error("level zero delivered");
    chk_no_reserved: assert property (coreReq |-> coreCode[4:0] != 5'h0b && coreCode[4:0] != 5'h0c)
        else $error("reserved source delivered");
    chk_mask_off: assert property (s_mask_off |-> ##2 !coreReq)
        else $error("mask zero did not block");
    chk_preempt_up: assert property (coreReq && $past(coreReq) && coreCode != $past(coreCode)
        |-> coreLevel > $past(coreLevel))
        else $error("replaced without higher level");
    chk_cur_read: assert property (s_read_cur |=> regRdData[16] == !$past(coreReq)
        && regRdData[10:8] == $past(coreLevel) && regRdData[4:0] == $past(coreCode[4:0]))
        else $error("current status mismatch");
    chk_read_idle: assert property (!regRd |=> regRdData == 32'h0)
        else $error("read data outside slot");
    chk_clear_zero: assert property (regRd && regAddr == `PIC_ADDR_CLEAR |=> !regRdData[8])
        else $error("clear enable reads one");
    chk_pend_rsvd: assert property (regRd && regAddr == `PIC_ADDR_PENDING
        |=> regRdData[12:11] == 2'b00)
        else $error("reserved pending set");
endmodule

// File: verification/pic_controller_bench.sv
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_controller_bench;
    import pic_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] srcLine = 16'hffff; // low-level sources idle high
    logic [31:0] regRdData;
    logic coreReq;
    pic_level_t coreLevel;
    logic [5:0] coreCode;
    logic [5:0] causeIp;
    int miscompares = 0;
    int n_tests = 0;
    pic_controller uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcLine(srcLine),
        .coreReq(coreReq), .coreLevel(coreLevel), .coreCode(coreCode));
    pic_core_model core (.clk(clk), .rst_n(rst_n), .coreReq(coreReq), .coreCode(coreCode),
        .causeIp(causeIp));
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobe then a gap cycle, so no strobe is assigned twice in one step
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("regRdData", exp, regRdData);
        @(posedge clk);
    endtask
    // lines need two sync flops, pending and delivery flop
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic code(input logic [5:0] c, input logic [2:0] l);
        chk("coreCode", {26'h0, c}, {26'h0, coreCode});
        chk("coreLevel", {29'h0, l}, {29'h0, coreLevel});
    endtask
    task automatic t_reset();
        rd(`PIC_ADDR_CURRENT, 32'h0001001f);
        code(6'h3f, 3'h0);
        rd(`PIC_ADDR_MODE_LO, 32'h0);
        rd(`PIC_ADDR_PENDING, 32'h0);
        rd(32'hfffec0f0, 32'h0);
    endtask
    task automatic t_tie();
        wr(`PIC_ADDR_LEVEL0 + 32'h4, 32'h400);
        wr(`PIC_ADDR_LEVEL0 + 32'h8, 32'h400);
        wr(`PIC_ADDR_MASK, 32'h1);
        wr(`PIC_ADDR_ENABLE, 32'h1);
        srcLine <= 16'hffd7;
        settle();
        code(6'h23, 3'h4);
        chk("causeIp", 32'h23, {26'h0, causeIp});
        rd(`PIC_ADDR_PENDING, 32'h28);
        rd(`PIC_ADDR_CURRENT, 32'h00000403);
    endtask
    task automatic t_preempt();
        wr(`PIC_ADDR_LEVEL0 + 32'h10, 32'h600);
        srcLine <= 16'hfdd7;
        settle();
        code(6'h29, 3'h6);
        wr(`PIC_ADDR_LEVEL0, 32'h600);
        srcLine <= 16'hfdd5;
        settle();
        code(6'h29, 3'h6);
        wr(`PIC_ADDR_LEVEL0 + 32'h10, 32'h0);
        settle();
        code(6'h29, 3'h6);
        wr(`PIC_ADDR_MASK, 32'h7);
        settle();
        chk("coreReq", 32'h0, {31'h0, coreReq});
        wr(`PIC_ADDR_MASK, 32'h1);
        settle();
        code(6'h21, 3'h6);
        srcLine <= 16'hffff;
        settle();
        chk("coreReq", 32'h0, {31'h0, coreReq});
    endtask
    task automatic t_edge();
        wr(`PIC_ADDR_MODE_LO, 32'h2);
        wr(`PIC_ADDR_LEVEL0, 32'h2);
        srcLine <= 16'hfffe;
        settle();
        srcLine <= 16'hffff;
        settle();
        code(6'h20, 3'h2);
        rd(`PIC_ADDR_PENDING, 32'h1);
        wr(`PIC_ADDR_CLEAR, 32'h100);
        #1;
        chk("coreReq", 32'h0, {31'h0, coreReq});
        @(posedge clk);
        rd(`PIC_ADDR_PENDING, 32'h0);
        rd(`PIC_ADDR_CLEAR, 32'h0);
        wr(`PIC_ADDR_MODE_LO, 32'h3);
        srcLine <= 16'hfffe;
        settle();
        rd(`PIC_ADDR_PENDING, 32'h1);
        wr(`PIC_ADDR_CLEAR, 32'h100);
        rd(`PIC_ADDR_PENDING, 32'h0);
        wr(`PIC_ADDR_MODE_LO, 32'h1);
        settle();
        rd(`PIC_ADDR_PENDING, 32'h0);
    endtask
    task automatic t_mask();
        srcLine <= 16'hfff7;
        wr(`PIC_ADDR_MASK, 32'h0);
        settle();
        chk("coreReq", 32'h0, {31'h0, coreReq});
        wr(`PIC_ADDR_MASK, 32'h5);
        settle();
        chk("coreReq", 32'h0, {31'h0, coreReq});
        wr(`PIC_ADDR_MASK, 32'h4);
        settle();
        code(6'h23, 3'h4);
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_tie();
        t_preempt();
        t_edge();
        t_mask();
        print_verdict();
    end
    // watchdog well past the roughly 170 cycles the tests take
    initial begin
        #50000;
        miscompares++;
        print_verdict();
    end
endmodule
bind pic_controller pic_controller_sva chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .srcLine(srcLine), .coreReq(coreReq), .coreLevel(coreLevel), .coreCode(coreCode));
